// ===== src/boot_flash_self_program_map.sv
// self-programming sequencer: control register, page buffer, rc-timed flash operations
// assumes the core strobes spm_exec for a store and obeys core_halt and fetch_ok
// Summary of operation
// - flash writes timed by rc oscillator ticks
// - each operation lasts 3.7 to 4.5 ms
// - system reset never aborts a running write
// - power-down sleep blocks control register writes
// - fuse picks boot section start at flash top
// - rww section unreadable while it programs
// - no_read_while_write section 0x7000-0x7fff stays readable while the rww section programs
// - 13-bit counter, 128-word pages
// - page index from pointer bits 15..8
// - buffer word from pointer bits 7..1
// - pointer bit zero is load byte select
// - only no_read_while_write code readable while the rww section programs
// - store allowed only four cycles after write
// - store enable held until operation ends
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_program_regs.svh"

module boot_flash_self_program_map (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic spm_exec,
    input wire logic [15:0] spm_z,
    input wire logic [15:0] spm_data,
    input wire logic power_down,
    input wire logic eeprom_write_active,
    input wire logic rc_osc,
    input wire logic [1:0] boot_size_select,
    input wire logic [14:0] fetch_addr,
    output logic fetch_ok,
    output logic core_halt,
    output logic [14:0] boot_start,
    output logic rww_busy_flag,
    input wire logic [6:0] buf_idx,
    output logic [15:0] buf_word,
    output logic flash_erase,
    output logic flash_write,
    output logic [7:0] flash_page,
    output logic lock_wr,
    output logic [7:0] lock_data,
    input wire logic [15:0] lpm_z,
    output logic [14:0] lpm_word,
    output logic lpm_byte_hi
);
    import flash_self_program_pkg::*;

    // ****************************************
    // state
    // ****************************************
    prog_op_t op_q;
    logic [12:0] cnt_q;
    logic halt_q;
    logic [7:0] page_q;
    logic en_q;
    logic [3:0] cmd_q;
    logic rww_busy_q;
    logic [127:0] bufv_q;
    logic [15:0] buf_mem [128];
    logic [2:0] win_q;
    logic ie_q;
    logic [7:0] rdata_q;
    logic [15:0] buf_word_q;
    logic [14:0] boot_start_q;
    logic lock_wr_q;
    logic [7:0] lock_data_q;
    logic [14:0] lpm_word_q;
    logic lpm_byte_hi_q;
    logic rc_s1_q, rc_s2_q, rc_s3_q, rc_lvl_q;

    // ****************************************
    // rc oscillator edge detect
    // ****************************************
    // the rc clock is foreign; its level counts only once stages two and three agree
    wire rc_agree = rc_s2_q == rc_s3_q;
    wire rc_tick = rc_agree && rc_s3_q && !rc_lvl_q;

    always_ff @(posedge clock) begin
        rc_s1_q <= rc_osc;
        rc_s2_q <= rc_s1_q;
        rc_s3_q <= rc_s2_q;
        if (!por_n) begin
            rc_lvl_q <= 1'b0;
        end else if (rc_agree) begin
            rc_lvl_q <= rc_s3_q;
        end
    end

    // ****************************************
    // decode
    // ****************************************
    wire busy = op_q != OP_IDLE;
    wire ctrl_hit = reg_addr == `SPM_CTRL_OFS;
    wire [4:0] low5 = reg_wdata[4:0];
    wire cmd_valid = low5 == `CMD_FILL || low5 == `CMD_ERASE || low5 == `CMD_WRITE
        || low5 == `CMD_LOCK || low5 == `CMD_REENABLE;
    // a sleeping core writes nothing; eeprom writes and running operations block the command bits, not the interrupt enable
    wire ctrl_wr = reg_wr && ctrl_hit && !power_down;
    wire cmd_ok = ctrl_wr && cmd_valid && !eeprom_write_active && !busy;
    wire spm_go = spm_exec && en_q && !busy && win_q != 3'h0;
    wire go_fill = spm_go && cmd_q == 4'b0000;
    wire go_erase = spm_go && cmd_q == 4'b0001;
    wire go_write = spm_go && cmd_q == 4'b0010;
    wire go_lock = spm_go && cmd_q == 4'b0100;
    wire go_reen = spm_go && cmd_q == 4'b1000;
    wire tgt_no_read_while_write = spm_z[15:12] == `NO_READ_WHILE_WRITE_PAGE_HI;
    wire [6:0] z_word = spm_z[7:1];
    wire prog_done = busy && rc_tick && cnt_q == 13'(`PROG_MIN_TICKS - 1);
    wire lapse = en_q && !busy && win_q == 3'h1 && !spm_go && !cmd_ok;
    // a system reset spares the operation state while a write runs
    wire op_clr = !por_n || (!rst_n && !busy);
    wire [7:0] ctrl_val = {ie_q, rww_busy_q, 1'b0, cmd_q, en_q};
    wire in_rww = fetch_addr < `NO_READ_WHILE_WRITE_START;
    wire [14:0] start_sel = boot_size_select == 2'b11 ? `BOOT_START_512 :
        boot_size_select == 2'b10 ? `BOOT_START_1K :
        boot_size_select == 2'b01 ? `BOOT_START_2K : `BOOT_START_4K;

    // ****************************************
    // operation sequencer
    // ****************************************
    always_ff @(posedge clock) begin
        if (op_clr) begin
            op_q <= OP_IDLE;
            cnt_q <= 13'h0000;
            halt_q <= 1'b0;
            page_q <= 8'h00;
            en_q <= 1'b0;
            cmd_q <= 4'h0;
            rww_busy_q <= 1'b0;
        end else begin
            if (busy && rc_tick) begin
                cnt_q <= cnt_q + 13'h0001;
            end
            unique case (op_q)
                OP_IDLE: begin
                    if (cmd_ok) begin
                        en_q <= 1'b1;
                        cmd_q <= low5[4:1];
                    end else if (lapse) begin
                        en_q <= 1'b0;
                        cmd_q <= 4'h0;
                    end else if (go_fill || go_reen) begin
                        en_q <= 1'b0;
                        cmd_q <= 4'h0;
                        rww_busy_q <= 1'b0;
                    end else if (go_lock) begin
                        op_q <= OP_LOCK;
                        cnt_q <= 13'h0000;
                    end else if (go_erase || go_write) begin
                        op_q <= go_erase ? OP_ERASE : OP_WRITE;
                        cnt_q <= 13'h0000;
                        page_q <= spm_z[15:8];
                        halt_q <= tgt_no_read_while_write;
                        if (!tgt_no_read_while_write) begin
                            rww_busy_q <= 1'b1;
                        end
                    end
                end
                OP_ERASE, OP_WRITE, OP_LOCK: begin
                    // store enable stays up for the whole operation
                    if (prog_done) begin
                        op_q <= OP_IDLE;
                        en_q <= 1'b0;
                        cmd_q <= 4'h0;
                        halt_q <= 1'b0;
                    end
                end
                default: begin
                    op_q <= OP_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // temporary page buffer
    // ****************************************
    // a word can be loaded once; reloading needs a buffer erase first
    always_ff @(posedge clock) begin
        if (op_clr || go_reen || (prog_done && op_q == OP_WRITE)) begin
            bufv_q <= '0;
        end else if (go_fill && !bufv_q[z_word]) begin
            bufv_q[z_word] <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (go_fill && !bufv_q[z_word]) begin
            buf_mem[z_word] <= spm_data;
        end
    end

    always_ff @(posedge clock) begin
        buf_word_q <= bufv_q[buf_idx] ? buf_mem[buf_idx] : `ERASED_WORD;
    end

    // ****************************************
    // register port and small outputs
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            win_q <= 3'h0;
            ie_q <= 1'b0;
            rdata_q <= `SPM_CTRL_RESET;
            lock_wr_q <= 1'b0;
            lock_data_q <= 8'hff;
            lpm_word_q <= 15'h0000;
            lpm_byte_hi_q <= 1'b0;
            boot_start_q <= `BOOT_START_4K;
        end else begin
            win_q <= cmd_ok ? `STORE_WINDOW : (win_q != 3'h0 ? win_q - 3'h1 : 3'h0);
            if (ctrl_wr) begin
                ie_q <= reg_wdata[`BIT_READY_IE];
            end
            rdata_q <= (reg_rd && ctrl_hit) ? ctrl_val : 8'h00;
            lock_wr_q <= go_lock;
            if (go_lock) begin
                lock_data_q <= spm_data[7:0];
            end
            lpm_word_q <= lpm_z[15:1];
            lpm_byte_hi_q <= lpm_z[0];
            boot_start_q <= start_sel;
        end
    end

    // only no_read_while_write code can be read while the rww section programs
    assign fetch_ok = !halt_q && !(rww_busy_q && in_rww);
    assign core_halt = halt_q;
    assign reg_rdata = rdata_q;
    assign boot_start = boot_start_q;
    assign rww_busy_flag = rww_busy_q;
    assign buf_word = buf_word_q;
    assign flash_erase = op_q == OP_ERASE;
    assign flash_write = op_q == OP_WRITE;
    assign flash_page = page_q;
    assign lock_wr = lock_wr_q;
    assign lock_data = lock_data_q;
    assign lpm_word = lpm_word_q;
    assign lpm_byte_hi = lpm_byte_hi_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!por_n || !rst_n);

    chk_window_lapse: assert property (
        cmd_ok ##1 (!spm_exec && !reg_wr)[*4] |=> !en_q)
        else $error("store enable outlived its four-cycle window");
    chk_en_held: assert property (busy |-> en_q)
        else $error("store enable dropped during an operation");
    chk_end_clears: assert property ($fell(busy) |-> !en_q)
        else $error("store enable not cleared at operation end");
    chk_prog_length: assert property (
        $fell(busy) |-> $past(cnt_q) == 13'(`PROG_MIN_TICKS - 1) && $past(rc_tick))
        else $error("operation ended off its rc tick count");
    chk_prog_bound: assert property (busy |-> cnt_q < 13'(`PROG_MAX_TICKS))
        else $error("operation ran past its longest time");
    chk_rc_timed: assert property ((busy && !rc_tick) |=> cnt_q == $past(cnt_q))
        else $error("write timer moved without an rc tick");
    chk_no_read_while_write_halt: assert property (
        (go_erase || go_write) && tgt_no_read_while_write |=> core_halt && !rww_busy_flag)
        else $error("no_read_while_write target did not halt the core");
    chk_rww_busy: assert property (
        (go_erase || go_write) && !tgt_no_read_while_write |=> rww_busy_flag && !core_halt)
        else $error("rww target did not raise busy");
    chk_rww_block: assert property (rww_busy_flag && in_rww |-> !fetch_ok)
        else $error("rww fetch allowed while busy");
    chk_no_read_while_write_read: assert property (!core_halt && !in_rww |-> fetch_ok)
        else $error("no_read_while_write fetch blocked");
    chk_page_take: assert property (
        (go_erase || go_write) |=> flash_page == $past(spm_z[15:8]))
        else $error("page index not taken from pointer high byte");
    chk_sleep_guard: assert property ((power_down && reg_wr && !en_q) |=> !en_q)
        else $error("control register written in power-down");
    chk_reset_survive: assert property (@(posedge clock) disable iff (!por_n)
        (busy && !rst_n && !prog_done) |=> busy)
        else $error("reset aborted a running write");
    // the flop shows its reset value for one edge after a system reset ends
    chk_lpm_byte: assert property ($past(rst_n) |-> lpm_byte_hi == $past(lpm_z[0]))
        else $error("load byte select not from pointer bit zero");
    chk_boot_start: assert property (
        (boot_size_select == 2'b10)[*2] |-> boot_start == `BOOT_START_1K)
        else $error("boot start does not follow the fuse");

    cov_erase_no_read_while_write: cover property (go_erase && tgt_no_read_while_write);
    cov_write_rww: cover property (go_write && !tgt_no_read_while_write);
    cov_lapse: cover property (lapse);
    cov_lock: cover property (go_lock);
endmodule
`default_nettype wire

// ===== shared/flash_self_program_regs.svh
// offsets, field positions, reset values and timing counts of the self-programming block
// assumes an 8-bit register port and a free-running calibrated rc oscillator
`ifndef FLASH_SELF_PROGRAM_REGS_SVH
`define FLASH_SELF_PROGRAM_REGS_SVH

// ****************************************
// register map
// ****************************************
`define SPM_CTRL_OFS 8'h68
`define SPM_CTRL_RESET 8'h00
`define BIT_STORE_EN 0
`define BIT_ERASE 1
`define BIT_WRITE 2
`define BIT_LOCK 3
`define BIT_REENABLE 4
`define BIT_RWW_BUSY 6
`define BIT_READY_IE 7

// valid low-five-bit command codes
`define CMD_FILL 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK 5'h09
`define CMD_REENABLE 5'h11

// ****************************************
// flash geometry
// ****************************************
`define NO_READ_WHILE_WRITE_START 15'h7000
`define NO_READ_WHILE_WRITE_PAGE_HI 4'h7
`define BOOT_START_512 15'h7e00
`define BOOT_START_1K 15'h7c00
`define BOOT_START_2K 15'h7800
`define BOOT_START_4K 15'h7000
`define ERASED_WORD 16'hffff

// ****************************************
// timing
// ****************************************
`define STORE_WINDOW 3'h4
`define RC_KHZ 1000
`define PROG_MIN_US 3700
`define PROG_MAX_US 4500
`define PROG_MIN_TICKS ((`PROG_MIN_US * `RC_KHZ + 999) / 1000)
`define PROG_MAX_TICKS ((`PROG_MAX_US * `RC_KHZ) / 1000)

`endif

// ===== shared/flash_self_program_pkg.sv
// types of the self-programming block
// assumes nothing beyond the compiler
package flash_self_program_pkg;

    typedef enum logic [3:0] {
        OP_IDLE = 4'b0001,
        OP_ERASE = 4'b0010,
        OP_WRITE = 4'b0100,
        OP_LOCK = 4'b1000
    } prog_op_t;

endpackage

// ===== test/boot_core_model.sv
// behavioural core that issues one store-program instruction after a control write
// assumes go is strobed in the same cycle as the control write and z, data held after it
`timescale 1ns/1ps
`default_nettype none

module boot_core_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [2:0] dly,
    input wire logic [15:0] z,
    input wire logic [15:0] data,
    output logic spm_exec,
    output logic [15:0] spm_z,
    output logic [15:0] spm_data
);
    logic [2:0] cnt_q = 3'h0;
    wire fire = (go && dly == 3'h1) || (!go && cnt_q == 3'h2);

    initial begin
        spm_exec = 1'b0;
        spm_z = 16'h0000;
        spm_data = 16'h0000;
    end

    // dly counts edges from the control write to the store; 5 or more misses on purpose
    always @(posedge clock) begin
        cnt_q <= go ? dly : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0);
        spm_exec <= fire;
        if (fire) begin
            spm_z <= {z[15:1], 1'b0};
            spm_data <= data;
        end else if (spm_exec) begin
            // released lines show the inverse, so a stale value is never taken
            spm_z <= ~spm_z;
            spm_data <= ~spm_data;
        end
    end
endmodule

`default_nettype wire

// ===== test/tb_boot_flash_self_program_map.sv
// self-checking bench for the self-programming sequencer
// assumes a 200 MHz clock and a free rc oscillator near 50 MHz
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_program_regs.svh"

module tb_boot_flash_self_program_map;
    logic clock = 1'b0, rst_n = 1'b0, por_n = 1'b0, rc_osc = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, power_down = 1'b0, eeprom_write_active = 1'b0;
    logic spm_exec, rww_busy_flag, fetch_ok, core_halt, flash_erase, flash_write, lpm_byte_hi;
    logic lock_wr;
    logic [15:0] spm_z, spm_data, buf_word, lpm_z = 16'h0000, z_r = 16'h0000, d_r = 16'h0000;
    logic [1:0] boot_size_select = 2'h0;
    logic [14:0] fetch_addr = 15'h0000, boot_start, lpm_word;
    logic [6:0] buf_idx = 7'h00;
    logic [7:0] flash_page, lock_data;
    logic go = 1'b0;
    logic [2:0] dly = 3'h0;
    int fail_count = 0, samples_checked = 0, rc_ticks = 0;

    always #2.5 clock = ~clock;
    // rc period unrelated to the system clock
    always #10.3 rc_osc = ~rc_osc;
    always @(posedge rc_osc) rc_ticks++;

    boot_flash_self_program_map boot_flash_self_program_map_inst (.clock, .rst_n, .por_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .spm_exec, .spm_z, .spm_data,
        .power_down, .eeprom_write_active, .rc_osc, .boot_size_select, .fetch_addr, .fetch_ok,
        .core_halt, .boot_start, .rww_busy_flag, .buf_idx, .buf_word, .flash_erase,
        .flash_write, .flash_page, .lock_wr, .lock_data, .lpm_z, .lpm_word, .lpm_byte_hi);
    boot_core_model boot_core_model_inst (.clock, .go, .dly, .z(z_r), .data(d_r),
        .spm_exec, .spm_z, .spm_data);

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] k,
                      input logic [15:0] z, input logic [15:0] w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        go <= 1'b1;
        dly <= k;
        z_r <= z;
        d_r <= w;
        @(posedge clock);
        reg_wr <= 1'b0;
        go <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", 16'(e), 16'(reg_rdata));
    endtask

    task automatic fetchchk(input logic [14:0] a, input logic e);
        @(posedge clock);
        fetch_addr <= a;
        #1 chk("fetch_ok", 16'(e), 16'(fetch_ok));
    endtask

    task automatic bufchk(input logic [6:0] i, input logic [15:0] e);
        @(posedge clock);
        buf_idx <= i;
        @(posedge clock);
        #1 chk("buf_word", e, buf_word);
    endtask

    // polls store enable until it reads clear, then counts rc edges since t0
    // t0 is taken by the caller right after the operation starts
    task automatic wait_op(input int t0);
        int n;
        logic en;
        n = 0;
        en = 1'b1;
        while (en !== 1'b0 && n < 10000) begin
            @(posedge clock);
            reg_addr <= `SPM_CTRL_OFS;
            reg_rd <= 1'b1;
            @(posedge clock);
            reg_rd <= 1'b0;
            #1 en = reg_rdata[`BIT_STORE_EN];
            n++;
        end
        if (en !== 1'b0) begin
            $display("unexpected op_end expected %h seen %h", 1'b0, en);
            fail_count++;
            give_verdict();
        end else begin
            n = rc_ticks - t0;
            samples_checked++;
            if (n < `PROG_MIN_TICKS - 1 || n > `PROG_MAX_TICKS) begin
                $display("unexpected op_ticks expected %0d seen %0d", `PROG_MIN_TICKS, n);
                fail_count++;
            end
        end
    endtask

    task automatic t_fuse();
        logic [14:0] e [4] = '{`BOOT_START_4K, `BOOT_START_2K, `BOOT_START_1K, `BOOT_START_512};
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            boot_size_select <= i[1:0];
            repeat (3) @(posedge clock);
            #1 chk("boot_start", 16'(e[i]), 16'(boot_start));
        end
        $display("fuse test done");
    endtask

    task automatic t_regs();
        rdchk(`SPM_CTRL_OFS, `SPM_CTRL_RESET);
        wr(8'h69, 8'(`CMD_ERASE), 3'h0, 16'h0000, 16'h0000);
        rdchk(8'h69, 8'h00);
        power_down <= 1'b1;
        wr(`SPM_CTRL_OFS, 8'h83, 3'h0, 16'h0000, 16'h0000);
        rdchk(`SPM_CTRL_OFS, 8'h00);
        power_down <= 1'b0;
        eeprom_write_active <= 1'b1;
        // interrupt enable is still stored, the command is not
        wr(`SPM_CTRL_OFS, 8'h83, 3'h0, 16'h0000, 16'h0000);
        rdchk(`SPM_CTRL_OFS, 8'h80);
        eeprom_write_active <= 1'b0;
        wr(`SPM_CTRL_OFS, 8'h00, 3'h0, 16'h0000, 16'h0000);
        $display("register test done");
    endtask

    task automatic t_lpm();
        @(posedge clock);
        lpm_z <= 16'h1235;
        @(posedge clock);
        #1 chk("lpm_word", 16'h091a, 16'(lpm_word));
        chk("lpm_byte_hi", 16'h0001, 16'(lpm_byte_hi));
        $display("load test done");
    endtask

    task automatic t_fill();
        wr(`SPM_CTRL_OFS, 8'(`CMD_FILL), 3'h1, 16'h0007, 16'habcd);
        wr(`SPM_CTRL_OFS, 8'(`CMD_FILL), 3'h4, 16'h0006, 16'h1111);
        bufchk(7'h03, 16'habcd);
        bufchk(7'h04, `ERASED_WORD);
        rdchk(`SPM_CTRL_OFS, 8'h00);
        $display("fill test done");
    endtask

    task automatic t_window();
        wr(`SPM_CTRL_OFS, 8'(`CMD_ERASE), 3'h5, 16'h0100, 16'h0000);
        repeat (6) @(posedge clock);
        #1 chk("flash_erase", 16'h0000, 16'(flash_erase));
        rdchk(`SPM_CTRL_OFS, 8'h00);
        $display("window test done");
    endtask

    task automatic t_write();
        int t0;
        wr(`SPM_CTRL_OFS, 8'(`CMD_WRITE), 3'h2, 16'h1200, 16'h0000);
        repeat (3) @(posedge clock);
        #1 chk("flash_write", 16'h0001, 16'(flash_write));
        t0 = rc_ticks;
        chk("flash_page", 16'h0012, 16'(flash_page));
        chk("rww_busy_flag", 16'h0001, 16'(rww_busy_flag));
        chk("core_halt", 16'h0000, 16'(core_halt));
        fetchchk(15'h0000, 1'b0);
        fetchchk(15'h6fff, 1'b0);
        fetchchk(15'h7000, 1'b1);
        fetchchk(15'h7fff, 1'b1);
        rdchk(`SPM_CTRL_OFS, 8'h45);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1 chk("flash_write", 16'h0001, 16'(flash_write));
        wait_op(t0);
        rdchk(`SPM_CTRL_OFS, 8'h40);
        bufchk(7'h03, `ERASED_WORD);
        fetchchk(15'h0000, 1'b0);
        wr(`SPM_CTRL_OFS, 8'(`CMD_REENABLE), 3'h4, 16'h0000, 16'h0000);
        repeat (5) @(posedge clock);
        #1 chk("rww_busy_flag", 16'h0000, 16'(rww_busy_flag));
        fetchchk(15'h0000, 1'b1);
        $display("page write test done");
    endtask

    task automatic t_no_read_while_write();
        int t0;
        wr(`SPM_CTRL_OFS, 8'(`CMD_ERASE), 3'h3, 16'h7e00, 16'h0000);
        repeat (4) @(posedge clock);
        #1 chk("core_halt", 16'h0001, 16'(core_halt));
        t0 = rc_ticks;
        chk("flash_erase", 16'h0001, 16'(flash_erase));
        chk("flash_page", 16'h007e, 16'(flash_page));
        chk("rww_busy_flag", 16'h0000, 16'(rww_busy_flag));
        wait_op(t0);
        @(posedge clock);
        #1 chk("core_halt", 16'h0000, 16'(core_halt));
        $display("boot erase test done");
    endtask

    // boot lock bit 11 programmed, every other lock bit left at one
    task automatic t_lock();
        int t0;
        wr(`SPM_CTRL_OFS, 8'(`CMD_LOCK), 3'h1, 16'h0001, 16'h00ef);
        @(posedge clock);
        #1 chk("lock_wr", 16'h0001, 16'(lock_wr));
        chk("lock_data", 16'h00ef, 16'(lock_data));
        @(posedge clock);
        #1 t0 = rc_ticks;
        chk("lock_wr", 16'h0000, 16'(lock_wr));
        chk("core_halt", 16'h0000, 16'(core_halt));
        chk("rww_busy_flag", 16'h0000, 16'(rww_busy_flag));
        wait_op(t0);
        chk("lock_data", 16'h00ef, 16'(lock_data));
        $display("lock test done");
    endtask

    initial begin
        repeat (3) @(posedge clock);
        por_n <= 1'b1;
        rst_n <= 1'b1;
        t_fuse();
        t_regs();
        t_lpm();
        t_fill();
        t_window();
        t_write();
        t_no_read_while_write();
        t_lock();
        give_verdict();
    end
endmodule

`default_nettype wire
